//--- verilog/asu_defines.svh
`ifndef ASU_DEFINES_SVH
`define ASU_DEFINES_SVH

`define ASU_WORD_W 16
`define ASU_CNT_W 6
`define ASU_CNT_LSB 0
`define ASU_RST_WORD 16'h0000
`define ASU_RST_CNT 6'h00
`define ASU_LIM_SGL 6'h0F
`define ASU_LIM_ASR 6'h0E
`define ASU_LIM_LONG 6'h1F
`define ASU_LIM_LAR 6'h1E
`define ASU_ROT_MOD 6'h20

`endif

//--- verilog/asu_pkg.sv
`default_nettype none
`include "asu_defines.svh"

package asu_pkg;

  typedef enum logic [2:0] {
    op_asl, op_asr, op_lll, op_llr, op_lrl, op_lrr, op_lal, op_lar
  } asu_op_t;

  typedef struct packed {
    logic carry;
    logic [`ASU_WORD_W-1:0] acc;
    logic [`ASU_WORD_W-1:0] ext;
  } asu_regs_t;

  typedef struct packed {
    asu_op_t op;
    logic [`ASU_WORD_W-1:0] instr;
    asu_regs_t regs;
  } asu_req_t;

endpackage

`default_nettype wire

//--- verilog/asu_shift_unit.sv
`default_nettype none
`include "asu_defines.svh"

module asu_shift_unit
  import asu_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // request from the sequencer
  input wire logic start,
  input wire asu_req_t req,
  output logic ready,
  // result and status
  output logic busy,
  output logic done,
  output asu_regs_t regs,
  output logic carry_status
);

  // ==========================================================
  // sequencing state
  typedef enum logic {st_idle, st_run} asu_state_t;

  asu_state_t state;
  asu_op_t op;
  logic [`ASU_CNT_W-1:0] cnt;
  logic sign_chg;

  wire logic take = start && (state == st_idle);
  wire logic cnt_zero = (cnt == `ASU_RST_CNT);
  wire logic stepping = (state == st_run) && !cnt_zero;
  wire logic finishing = (state == st_run) && cnt_zero;
  wire logic [`ASU_CNT_W-1:0] req_cnt =
    req.instr[`ASU_CNT_LSB +: `ASU_CNT_W];

  assign ready = (state == st_idle);
  assign busy = (state == st_run);
  // carry is only final once the unit is idle again
  assign carry_status = regs.carry && (state == st_idle);

  // ==========================================================
  // one-position step for each operation
  wire logic [15:0] a = regs.acc;
  wire logic [15:0] b = regs.ext;
  wire logic c = regs.carry;

  wire asu_regs_t s_asl = '{c, {a[14:0], 1'b0}, b};
  wire asu_regs_t s_asr = '{a[0], {a[15], a[15:1]}, b};
  wire asu_regs_t s_lll = '{a[15], {a[14:0], b[15]}, {b[14:0], 1'b0}};
  wire asu_regs_t s_llr = '{b[0], {1'b0, a[15:1]}, {a[0], b[15:1]}};
  wire asu_regs_t s_lrl = '{a[15], {a[14:0], b[15]}, {b[14:0], a[15]}};
  wire asu_regs_t s_lrr = '{b[0], {b[0], a[15:1]}, {a[0], b[15:1]}};
  // extension sign stays put; magnitude bits feed the accumulator
  wire asu_regs_t s_lal = '{c, {a[14:0], b[14]}, {b[15], b[13:0], 1'b0}};
  wire asu_regs_t s_lar = '{b[0], {a[15], a[15:1]}, {b[15], a[0], b[14:1]}};

  wire asu_regs_t next_step =
    (op == op_asl) ? s_asl :
    (op == op_asr) ? s_asr :
    (op == op_lll) ? s_lll :
    (op == op_llr) ? s_llr :
    (op == op_lrl) ? s_lrl :
    (op == op_lrr) ? s_lrr :
    (op == op_lal) ? s_lal : s_lar;

  // overflow ops report sign change instead of the shifted-out bit
  wire logic ovf_op = (op == op_asl) || (op == op_lal);
  wire logic next_sign_chg = sign_chg || (a[15] != a[14]);

  wire asu_regs_t next_final = '{ovf_op ? sign_chg : c, a, b};

  wire asu_regs_t next_regs =
    take ? req.regs :
    stepping ? next_step :
    finishing ? next_final : regs;

  // ==========================================================
  // registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      regs <= '{1'b0, `ASU_RST_WORD, `ASU_RST_WORD};
    end else begin
      regs <= next_regs;
    end
  end

  // down-counter: a count of N costs N step cycles plus one finish cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt <= `ASU_RST_CNT;
    end else if (take) begin
      cnt <= req_cnt;
    end else if (stepping) begin
      cnt <= cnt - 6'h01;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sign_chg <= 1'b0;
    end else if (take) begin
      sign_chg <= 1'b0;
    end else if (stepping) begin
      sign_chg <= next_sign_chg;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      op <= op_asl;
    end else if (take) begin
      op <= req.op;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      done <= 1'b0;
    end else begin
      done <= finishing;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= st_idle;
    end else begin
      case (state)
        st_idle: begin
          if (start) begin
            state <= st_run;
          end
        end
        st_run: begin
          if (cnt_zero) begin
            state <= st_idle;
          end
        end
        default: begin
          state <= st_idle;
        end
      endcase
    end
  end

  // ==========================================================
  // checking helpers
  asu_regs_t prev;
  logic [`ASU_CNT_W-1:0] cnt_taken;
  logic [6:0] run_cycles;
  logic start_sign;
  logic [31:0] start_ae;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prev <= '{1'b0, `ASU_RST_WORD, `ASU_RST_WORD};
      cnt_taken <= `ASU_RST_CNT;
      run_cycles <= 7'h00;
      start_sign <= 1'b0;
      start_ae <= 32'h0000_0000;
    end else begin
      prev <= regs;
      if (take) begin
        cnt_taken <= req_cnt;
        run_cycles <= 7'h00;
        start_sign <= req.regs.acc[15];
        start_ae <= {req.regs.acc, req.regs.ext};
      end else if (busy) begin
        run_cycles <= run_cycles + 7'h01;
      end
    end
  end

  wire logic [5:0] rot_k = cnt_taken - `ASU_ROT_MOD;
  wire logic [63:0] dbl_l = {start_ae, start_ae} << rot_k;
  wire logic [63:0] dbl_r = {start_ae, start_ae} >> rot_k;
  wire logic [31:0] ae_now = {regs.acc, regs.ext};

  // ==========================================================
  // assertions
  a_count_field: assert property (
    @(posedge mclk) disable iff (rst)
    take |=> (cnt == $past(req_cnt)) && busy
  ) else $error("count not taken from low six bits");

  a_step_total: assert property (
    @(posedge mclk) disable iff (rst)
    done |-> (run_cycles == {1'b0, cnt_taken} + 7'h01)
  ) else $error("step count differs from requested count");

  a_down_count: assert property (
    @(posedge mclk) disable iff (rst)
    stepping |=> (cnt == $past(cnt) - 6'h01) && busy
  ) else $error("counter did not step down by one");

  a_done_when_zero: assert property (
    @(posedge mclk) disable iff (rst)
    finishing |=> done && ready ##1 !done
  ) else $error("done not one pulse after count reached zero");

  a_asl_step: assert property (
    @(posedge mclk) disable iff (rst)
    stepping && (op == op_asl) |=>
      (regs.acc == {prev.acc[14:0], 1'b0}) && (regs.ext == prev.ext)
  ) else $error("single left shift step wrong");

  a_asl_carry: assert property (
    @(posedge mclk) disable iff (rst)
    done && (op == op_asl) && (regs.acc[15] != start_sign) |-> regs.carry
  ) else $error("sign changed but carry clear");

  a_asl_no_ovf: assert property (
    @(posedge mclk) disable iff (rst)
    done && (op == op_asl) && (cnt_taken == 6'h00) |-> !regs.carry
  ) else $error("carry set with no shift");

  a_asl_big: assert property (
    @(posedge mclk) disable iff (rst)
    done && (op == op_asl) && (cnt_taken > `ASU_LIM_SGL) |->
      (regs.acc == 16'h0000)
  ) else $error("large single left shift not zero");

  a_asr_step: assert property (
    @(posedge mclk) disable iff (rst)
    stepping && (op == op_asr) |=>
      (regs.acc == {prev.acc[15], prev.acc[15:1]}) &&
      (regs.carry == prev.acc[0])
  ) else $error("single right shift step wrong");

  a_asr_big: assert property (
    @(posedge mclk) disable iff (rst)
    done && (op == op_asr) && (cnt_taken > `ASU_LIM_ASR) |->
      (regs.acc[14:0] == {15{regs.acc[15]}}) && (regs.acc[15] == start_sign)
  ) else $error("large single right shift not sign filled");

  a_lll_step: assert property (
    @(posedge mclk) disable iff (rst)
    stepping && (op == op_lll) |=>
      (ae_now == {prev.acc[14:0], prev.ext, 1'b0}) &&
      (regs.carry == prev.acc[15])
  ) else $error("long left shift step wrong");

  a_long_zero: assert property (
    @(posedge mclk) disable iff (rst)
    done && ((op == op_lll) || (op == op_llr)) &&
      (cnt_taken > `ASU_LIM_LONG) |-> (ae_now == 32'h0000_0000)
  ) else $error("large long logical shift not zero");

  a_llr_step: assert property (
    @(posedge mclk) disable iff (rst)
    stepping && (op == op_llr) |=>
      (ae_now == {1'b0, prev.acc, prev.ext[15:1]}) &&
      (regs.carry == prev.ext[0])
  ) else $error("long right shift step wrong");

  a_lrl_step: assert property (
    @(posedge mclk) disable iff (rst)
    stepping && (op == op_lrl) |=>
      (ae_now == {prev.acc[14:0], prev.ext, prev.acc[15]}) &&
      (regs.carry == prev.acc[15])
  ) else $error("long rotate left step wrong");

  a_lrr_step: assert property (
    @(posedge mclk) disable iff (rst)
    stepping && (op == op_lrr) |=>
      (ae_now == {prev.ext[0], prev.acc, prev.ext[15:1]}) &&
      (regs.carry == prev.ext[0])
  ) else $error("long rotate right step wrong");

  a_rot_modulo: assert property (
    @(posedge mclk) disable iff (rst)
    done && (cnt_taken > `ASU_LIM_LONG) |->
      ((op != op_lrl) || (ae_now == dbl_l[63:32])) &&
      ((op != op_lrr) || (ae_now == dbl_r[31:0]))
  ) else $error("long rotate not modulo 32");

  a_lal_step: assert property (
    @(posedge mclk) disable iff (rst)
    stepping && (op == op_lal) |=>
      (regs.acc == {prev.acc[14:0], prev.ext[14]}) &&
      (regs.ext == {prev.ext[15], prev.ext[13:0], 1'b0})
  ) else $error("long arithmetic left step wrong");

  a_lal_carry: assert property (
    @(posedge mclk) disable iff (rst)
    done && (op == op_lal) && (regs.acc[15] != start_sign) |-> regs.carry
  ) else $error("long sign changed but carry clear");

  a_lal_big: assert property (
    @(posedge mclk) disable iff (rst)
    done && (op == op_lal) && (cnt_taken > `ASU_LIM_LONG) |->
      (regs.acc == 16'h0000) && (regs.ext[14:0] == 15'h0000)
  ) else $error("large long arithmetic left not zero");

  a_lar_step: assert property (
    @(posedge mclk) disable iff (rst)
    stepping && (op == op_lar) |=>
      (regs.acc == {prev.acc[15], prev.acc[15:1]}) &&
      (regs.ext == {prev.ext[15], prev.acc[0], prev.ext[14:1]}) &&
      (regs.carry == prev.ext[0])
  ) else $error("long arithmetic right step wrong");

  a_lar_big: assert property (
    @(posedge mclk) disable iff (rst)
    done && (op == op_lar) && (cnt_taken > `ASU_LIM_LAR) |->
      (regs.acc[14:0] == {15{regs.acc[15]}}) &&
      (regs.ext[14:0] == {15{regs.acc[15]}})
  ) else $error("large long arithmetic right not sign filled");

  a_carry_status: assert property (
    @(posedge mclk) disable iff (rst)
    done |-> (carry_status == regs.carry)
  ) else $error("carry status disagrees with carry");

  // ==========================================================
  // coverage
  c_max_count: cover property (
    @(posedge mclk) disable iff (rst)
    done && (cnt_taken == 6'h3F)
  );

  c_zero_count: cover property (
    @(posedge mclk) disable iff (rst)
    take && (req_cnt == 6'h00) ##2 done
  );

  c_asl_overflow: cover property (
    @(posedge mclk) disable iff (rst)
    done && (op == op_asl) && regs.carry
  );

  c_rotate_wrap: cover property (
    @(posedge mclk) disable iff (rst)
    done && (op == op_lrr) && (cnt_taken > `ASU_LIM_LONG)
  );

  c_back_to_back: cover property (
    @(posedge mclk) disable iff (rst)
    done ##0 take
  );

endmodule

`default_nettype wire

//--- dv/asu_seq_model.sv
`default_nettype none

module asu_seq_model
  import asu_pkg::*;
(
  // clock
  input wire logic mclk,
  // handshake with the unit
  input wire logic ready,
  output logic start,
  output asu_req_t req
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    start = 1'b0;
    req = '0;
  end

  // ==========================================================
  // request drivers
  // request stays up until an edge samples ready high
  task automatic issue(input asu_req_t r, input int gap);
    repeat (gap) @(posedge mclk);
    start <= 1'b1;
    req <= r;
    do @(posedge mclk); while (ready !== 1'b1);
    start <= 1'b0;
    // a released request must not keep showing its last value
    req <= ~r;
  endtask

  // one-cycle strobe regardless of ready, used to try a refused take
  task automatic intrude(input asu_req_t r);
    @(posedge mclk);
    start <= 1'b1;
    req <= r;
    @(posedge mclk);
    start <= 1'b0;
    req <= ~r;
  endtask
endmodule

`default_nettype wire

//--- dv/tb.sv
`default_nettype none

module tb
  import asu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic mclk;
  logic rst;
  logic start;
  logic ready;
  logic busy;
  logic done;
  logic carry_status;
  asu_req_t req;
  asu_regs_t regs;
  int err_count;
  int check_count;
  int seed;
  logic [5:0] cnts [9] = '{6'h00, 6'h01, 6'h0E, 6'h0F, 6'h10, 6'h1E, 6'h1F, 6'h21, 6'h3F};

  always #4 mclk = ~mclk;

  asu_shift_unit dut_u (
    .mclk(mclk),
    .rst(rst),
    .start(start),
    .req(req),
    .ready(ready),
    .busy(busy),
    .done(done),
    .regs(regs),
    .carry_status(carry_status)
  );

  asu_seq_model seq_u (
    .mclk(mclk),
    .ready(ready),
    .start(start),
    .req(req)
  );

  // ==========================================================
  // reference and checking
  function automatic asu_regs_t ref_run(asu_op_t op, asu_regs_t r, int n);
    logic chg;
    chg = 1'b0;
    for (int i = 0; i < n; i++) begin
      case (op)
        op_asl: begin
          chg |= r.acc[15] ^ r.acc[14];
          r.acc = {r.acc[14:0], 1'b0};
        end
        op_asr: begin
          r.carry = r.acc[0];
          r.acc = {r.acc[15], r.acc[15:1]};
        end
        op_lll: {r.carry, r.acc, r.ext} = {r.acc, r.ext, 1'b0};
        op_llr: {r.acc, r.ext, r.carry} = {1'b0, r.acc, r.ext};
        op_lrl: {r.carry, r.acc, r.ext} = {r.acc[15], r.acc[14:0], r.ext, r.acc[15]};
        op_lrr: {r.acc, r.ext, r.carry} = {r.ext[0], r.acc, r.ext[15:1], r.ext[0]};
        op_lal: begin
          chg |= r.acc[15] ^ r.acc[14];
          {r.acc, r.ext[14:0]} = {r.acc[14:0], r.ext[14:0], 1'b0};
        end
        default: begin
          r.carry = r.ext[0];
          r.ext = {r.ext[15], r.acc[0], r.ext[14:1]};
          r.acc = {r.acc[15], r.acc[15:1]};
        end
      endcase
    end
    // overflow ops report a sign change seen at any step
    if (op == op_asl || op == op_lal) begin
      r.carry = chg;
    end
    return r;
  endfunction

  function automatic asu_regs_t rnd_regs();
    return asu_regs_t'(33'({$random(seed), $random(seed)}));
  endfunction

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic run_one(asu_op_t op, logic [15:0] instr, asu_regs_t r, int gap);
    asu_req_t q;
    asu_regs_t e;
    asu_regs_t m;
    int n;
    int k;
    n = int'(instr[5:0]);
    q = '{op: op, instr: instr, regs: r};
    e = ref_run(op, r, n);
    m = ref_run(op, r, n % 32);
    k = 0;
    seq_u.issue(q, gap);
    do begin
      @(posedge mclk);
      #1;
      k++;
    end while (done !== 1'b1 && k < 80);
    // issue returns on the taking edge; done is seen after n steps and the finish edge
    check(33'(k), 33'(n + 1));
    check(regs, e);
    check(33'(carry_status), 33'(e.carry));
    if (op == op_asl && n > 15) check(33'(regs.acc), 33'h0);
    if (op == op_asr && n > 14) check(33'(regs.acc[14:0]), {33{r.acc[15]}} & 33'h7FFF);
    if ((op == op_lll || op == op_llr) && n > 31) check(33'({regs.acc, regs.ext}), 33'h0);
    if ((op == op_lrl || op == op_lrr) && n > 31)
      check({1'b0, regs.acc, regs.ext}, {1'b0, m.acc, m.ext});
    if (op == op_lal && n > 31) check(33'({regs.acc, regs.ext[14:0]}), 33'h0);
    if (op == op_lar && n > 30)
      check(33'({regs.acc[14:0], regs.ext[14:0]}), {33{r.acc[15]}} & 33'h3FFFFFFF);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ==========================================================
  // tests
  initial begin
    seed = 23;
    mclk = 1'b0;
    rst = 1'b1;
    err_count = 0;
    check_count = 0;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    check(regs, 33'h0);
    check(33'({ready, busy, done, carry_status}), 33'h8);
    $display("test reset done");
    // every op at the boundary counts; upper instruction bits are noise
    foreach (cnts[j]) begin
      for (int o = 0; o < 8; o++) begin
        run_one(asu_op_t'(3'(o)), {10'h2AB, cnts[j]}, rnd_regs(), 1);
      end
    end
    $display("test corner done");
    // sign flips and flips back: the flag must still be set
    run_one(op_asl, 16'hFFC2, '{carry: 1'b0, acc: 16'h4000, ext: 16'h0000}, 1);
    run_one(op_lal, 16'h0002, '{carry: 1'b0, acc: 16'h4000, ext: 16'h8000}, 2);
    $display("test sign flip done");
    // a start while busy must be ignored
    fork
      run_one(op_lll, 16'h0014, rnd_regs(), 1);
      begin
        repeat (4) @(posedge mclk);
        seq_u.intrude('{op: op_asl, instr: 16'h0000, regs: 33'h1FFFFFFFF});
      end
    join
    $display("test refuse done");
    repeat (40) begin
      run_one(asu_op_t'(3'($random(seed))), 16'($random(seed)), rnd_regs(),
              1 + ($random(seed) & 3));
    end
    $display("test random done");
    report_and_stop();
  end

  // the whole run needs well under 12000 cycles
  initial begin
    #(30000 * 8);
    err_count++;
    report_and_stop();
  end
endmodule

`default_nettype wire
